//--- fux_consts.svh
// Offsets, field positions, reset values and counts of the FP exception unit
`ifndef FUX_CONSTS_SVH
`define FUX_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FUX_OFF_CSR 4'h0
`define FUX_OFF_CFG 4'h1
`define FUX_OFF_EPC_LO 4'h2
`define FUX_OFF_EPC_HI 4'h3
`define FUX_OFF_XFER 4'h4
// ----------------------------------------
// Control/status and configuration fields (cause order: I U O Z V E)
// ----------------------------------------
`define FUX_RM_LO 5'h00
`define FUX_FLAG_LO 5'h02
`define FUX_EN_LO 5'h07
`define FUX_CAUSE_LO 5'h0C
`define FUX_FS_BIT 5'h18
`define FUX_WIDE_BIT 5'h00
`define FUX_C_I 3'h0
`define FUX_C_U 3'h1
`define FUX_C_O 3'h2
`define FUX_C_Z 3'h3
`define FUX_C_V 3'h4
`define FUX_C_E 3'h5
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define FUX_CSR_RST 32'h0000_0000
`define FUX_XFER_NARROW 6'h10
`define FUX_XFER_WIDE 6'h20
`define FUX_EMIN_S 13'sh1F82
`define FUX_EMIN_D 13'sh1C02
`define FUX_MIN_S 64'h0000_0000_0080_0000
`define FUX_MIN_D 64'h0010_0000_0000_0000
`define FUX_SIGN_S 6'h1F
`define FUX_SIGN_D 6'h3F
`endif

//--- fux_pkg.sv
// Types shared by the FP exception unit
package fux_pkg;
	typedef enum logic [1:0] {FUX_CLS_COMPUTE, FUX_CLS_CONVERT,
		FUX_CLS_COMPARE, FUX_CLS_MOVE} fux_cls_t;
	typedef enum logic [2:0] {FUX_FMT_S, FUX_FMT_D, FUX_FMT_W, FUX_FMT_L,
		FUX_FMT_RSVD} fux_fmt_t;
	typedef enum logic [1:0] {FUX_RM_RN, FUX_RM_RZ, FUX_RM_RP,
		FUX_RM_RM} fux_rm_t;
endpackage : fux_pkg

//--- fux_dec_if.sv
// Decision signals between the exception unit and its two checkers
`timescale 1ns/1ps
`default_nettype none
interface fux_dec_if;
	fux_pkg::fux_cls_t cls;
	fux_pkg::fux_fmt_t fmt;
	fux_pkg::fux_rm_t rm;
	logic op_reserved;
	logic fmt_invalid;
	logic [1:0] denorm;
	logic [1:0] qnan;
	logic tiny;
	logic sign;
	logic fs;
	logic en_u;
	logic en_i;
	logic unimpl_op;
	logic uf_trap;
	logic uf_flush;
	logic [63:0] flush_val;
	modport src(output cls, fmt, rm, op_reserved, fmt_invalid, denorm, qnan,
		tiny, sign, fs, en_u, en_i, input unimpl_op, uf_trap, uf_flush,
		flush_val);
	modport chk(input cls, fmt, op_reserved, fmt_invalid, denorm, qnan,
		output unimpl_op);
	modport flu(input fmt, rm, tiny, sign, fs, en_u, en_i, output uf_trap,
		uf_flush, flush_val);
endinterface : fux_dec_if
`default_nettype wire

//--- fux_op_check.sv
// Opcode, format and operand screening for unimplemented operations
`timescale 1ns/1ps
`default_nettype none
module fux_op_check (
	fux_dec_if.chk dec
);
	logic opnd_odd;
	logic checked_cls;

	// Moves and compares pass odd operands through
	assign checked_cls = (dec.cls == fux_pkg::FUX_CLS_COMPUTE) ||
		(dec.cls == fux_pkg::FUX_CLS_CONVERT);
	assign opnd_odd = |(dec.denorm | dec.qnan);
	assign dec.unimpl_op = dec.op_reserved ||
		(dec.fmt == fux_pkg::FUX_FMT_RSVD) ||
		dec.fmt_invalid ||
		(checked_cls && opnd_odd);
endmodule : fux_op_check
`default_nettype wire

//--- fux_uf_flush.sv
// Underflow trap decision and flushed result value
`timescale 1ns/1ps
`default_nettype none
`include "fux_consts.svh"
module fux_uf_flush (
	fux_dec_if.flu dec
);
	logic [63:0] min_mag;
	logic [5:0] sign_pos;
	logic [63:0] sign_bit;

	assign dec.uf_trap = dec.tiny && (dec.en_u || dec.en_i || !dec.fs);
	assign dec.uf_flush = dec.tiny && !dec.en_u && !dec.en_i && dec.fs;
	assign min_mag = (dec.fmt == fux_pkg::FUX_FMT_D) ? `FUX_MIN_D : `FUX_MIN_S;
	assign sign_pos = (dec.fmt == fux_pkg::FUX_FMT_D) ? `FUX_SIGN_D : `FUX_SIGN_S;
	assign sign_bit = 64'h0000_0000_0000_0001 << sign_pos;

	// Value chosen from rounding mode and intermediate sign
	always_comb begin
		dec.flush_val = 64'h0;
		unique case (dec.rm)
			fux_pkg::FUX_RM_RN, fux_pkg::FUX_RM_RZ: begin
				dec.flush_val = dec.sign ? sign_bit : 64'h0;
			end
			fux_pkg::FUX_RM_RP: begin
				dec.flush_val = dec.sign ? sign_bit : min_mag;
			end
			fux_pkg::FUX_RM_RM: begin
				dec.flush_val = dec.sign ? (sign_bit | min_mag) : 64'h0;
			end
		endcase
	end
endmodule : fux_uf_flush
`default_nettype wire

//--- fux_exc_unit.sv
// Top of the FP coprocessor underflow and unimplemented-operation unit
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fux_consts.svh"
module fux_exc_unit #(
	parameter int ADDR_W = 4,
	parameter int PC_W = 64
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic iss_valid,
	input wire fux_pkg::fux_cls_t iss_cls,
	input wire fux_pkg::fux_fmt_t iss_fmt,
	input wire logic [PC_W-1:0] iss_pc,
	input wire logic op_reserved,
	input wire logic fmt_invalid,
	input wire logic [1:0] opnd_denorm,
	input wire logic [1:0] opnd_qnan,
	input wire logic res_nonzero,
	input wire logic signed [12:0] res_exp,
	input wire logic res_sign,
	input wire logic res_inexact,
	input wire logic res_overflow,
	input wire logic res_divzero,
	input wire logic res_invalid,
	output logic iss_ready,
	output logic res_wr,
	output logic res_flush,
	output logic [63:0] res_flush_val,
	output logic trap,
	output logic [PC_W-1:0] trap_epc,
	output logic [5:0] cause,
	output logic wide_regs,
	output logic [5:0] xfer_count
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (ADDR_W < 3) begin : g_addr_chk
		$error("ADDR_W must be at least 3");
	end
	if (PC_W < 32 || PC_W > 64) begin : g_pc_chk
		$error("PC_W must lie in 32..64");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic fux_tiny(input logic nz,
		input logic signed [12:0] ex, input fux_pkg::fux_fmt_t f);
		logic signed [12:0] emin;
		emin = (f == fux_pkg::FUX_FMT_D) ? `FUX_EMIN_D : `FUX_EMIN_S;
		return nz && (ex < emin);
	endfunction : fux_tiny

	function automatic logic fux_pending(input logic [5:0] c,
		input logic [4:0] en);
		return c[`FUX_C_E] || (|(c[4:0] & en));
	endfunction : fux_pending

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [1:0] rm_ff;
	logic [4:0] flags_ff;
	logic [4:0] en_ff;
	logic [5:0] cause_ff;
	logic fs_ff;
	logic wide_ff;
	logic [PC_W-1:0] epc_ff;
	logic [31:0] rdata_ff;
	logic ready_ff;
	logic res_wr_ff;
	logic res_flush_ff;
	logic [63:0] flush_val_ff;
	logic trap_ff;
	logic [5:0] xfer_ff;
	logic [5:0] nxt_cause;
	logic [4:0] nxt_flags;
	logic [4:0] nxt_en;
	logic [5:0] op_cause;
	logic iss_acc;
	logic csr_wr;
	logic cfg_wr;
	logic unimpl;
	logic take_trap;
	logic [63:0] epc_wide;
	logic [31:0] csr_word;
	fux_dec_if dec ();

	assign iss_acc = iss_valid && ready_ff;
	assign csr_wr = reg_wr && (reg_addr == ADDR_W'(`FUX_OFF_CSR));
	assign cfg_wr = reg_wr && (reg_addr == ADDR_W'(`FUX_OFF_CFG));

	// ----------------------------------------
	// Checkers
	// ----------------------------------------
	assign dec.cls = iss_cls;
	assign dec.fmt = iss_fmt;
	assign dec.rm = fux_pkg::fux_rm_t'(rm_ff);
	assign dec.op_reserved = op_reserved;
	assign dec.fmt_invalid = fmt_invalid;
	assign dec.denorm = opnd_denorm;
	assign dec.qnan = opnd_qnan;
	assign dec.tiny = fux_tiny(res_nonzero, res_exp, iss_fmt);
	assign dec.sign = res_sign;
	assign dec.fs = fs_ff;
	assign dec.en_u = en_ff[`FUX_C_U];
	assign dec.en_i = en_ff[`FUX_C_I];

	fux_op_check u_check (
		.dec(dec.chk)
	);

	fux_uf_flush u_flush (
		.dec(dec.flu)
	);

	// ----------------------------------------
	// Cause and trap decision
	// ----------------------------------------
	assign unimpl = dec.unimpl_op || dec.uf_trap;

	always_comb begin
		op_cause = 6'h00;
		if (unimpl) begin
			op_cause[`FUX_C_E] = 1'b1;
		end else begin
			op_cause[`FUX_C_I] = res_inexact || res_overflow ||
				dec.uf_flush;
			op_cause[`FUX_C_U] = dec.uf_flush;
			op_cause[`FUX_C_O] = res_overflow;
			op_cause[`FUX_C_Z] = res_divzero;
			op_cause[`FUX_C_V] = res_invalid;
		end
	end

	// Unimplemented has no enable bit
	assign take_trap = unimpl || (|(op_cause[4:0] & en_ff));

	always_comb begin
		nxt_cause = cause_ff;
		if (csr_wr) begin
			nxt_cause = reg_wdata[`FUX_CAUSE_LO +: 6];
		end
		// Hardware set wins over a same-cycle write
		if (iss_acc) begin
			nxt_cause = (csr_wr ? reg_wdata[`FUX_CAUSE_LO +: 6] : 6'h00) |
				op_cause;
		end
	end

	always_comb begin
		nxt_flags = csr_wr ? reg_wdata[`FUX_FLAG_LO +: 5] : flags_ff;
		if (iss_acc && !take_trap) begin
			nxt_flags = nxt_flags | op_cause[4:0];
		end
	end

	assign nxt_en = csr_wr ? reg_wdata[`FUX_EN_LO +: 5] : en_ff;

	// ----------------------------------------
	// Control/status register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cause_ff <= 6'h00;
			flags_ff <= 5'h00;
			en_ff <= 5'h00;
		end else begin
			cause_ff <= nxt_cause;
			flags_ff <= nxt_flags;
			en_ff <= nxt_en;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rm_ff <= 2'h0;
			fs_ff <= 1'b0;
		end else if (csr_wr) begin
			rm_ff <= reg_wdata[`FUX_RM_LO +: 2];
			fs_ff <= reg_wdata[`FUX_FS_BIT];
		end
	end

	// ----------------------------------------
	// Register-set width and save count
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wide_ff <= 1'b0;
			xfer_ff <= `FUX_XFER_NARROW;
		end else if (cfg_wr) begin
			wide_ff <= reg_wdata[`FUX_WIDE_BIT];
			xfer_ff <= reg_wdata[`FUX_WIDE_BIT] ? `FUX_XFER_WIDE :
				`FUX_XFER_NARROW;
		end
	end

	// ----------------------------------------
	// Issue, result and precise trap
	// ----------------------------------------
	// A pending unimplemented cause or an enabled pending cause holds issue off, so nothing later retires
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= !fux_pending(nxt_cause, nxt_en);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			res_wr_ff <= 1'b0;
			res_flush_ff <= 1'b0;
			flush_val_ff <= 64'h0;
		end else begin
			res_wr_ff <= iss_acc && !take_trap;
			res_flush_ff <= iss_acc && !take_trap && dec.uf_flush;
			flush_val_ff <= dec.flush_val;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			trap_ff <= 1'b0;
		end else begin
			trap_ff <= iss_acc && take_trap;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			epc_ff <= '0;
		end else if (iss_acc && take_trap) begin
			epc_ff <= iss_pc;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_comb begin
		csr_word = `FUX_CSR_RST;
		csr_word[`FUX_RM_LO +: 2] = rm_ff;
		csr_word[`FUX_FLAG_LO +: 5] = flags_ff;
		csr_word[`FUX_EN_LO +: 5] = en_ff;
		csr_word[`FUX_CAUSE_LO +: 6] = cause_ff;
		csr_word[`FUX_FS_BIT] = fs_ff;
	end

	assign epc_wide = 64'(epc_ff);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_ff <= 32'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_W'(`FUX_OFF_CSR): rdata_ff <= csr_word;
				ADDR_W'(`FUX_OFF_CFG): rdata_ff <= {31'h0, wide_ff};
				ADDR_W'(`FUX_OFF_EPC_LO): rdata_ff <= epc_wide[31:0];
				ADDR_W'(`FUX_OFF_EPC_HI): rdata_ff <= epc_wide[63:32];
				ADDR_W'(`FUX_OFF_XFER): rdata_ff <= {26'h0, xfer_ff};
				default: rdata_ff <= 32'h0;
			endcase
		end else begin
			rdata_ff <= 32'h0;
		end
	end

	assign reg_rdata = rdata_ff;
	assign iss_ready = ready_ff;
	assign res_wr = res_wr_ff;
	assign res_flush = res_flush_ff;
	assign res_flush_val = flush_val_ff;
	assign trap = trap_ff;
	assign trap_epc = epc_ff;
	assign cause = cause_ff;
	assign wide_regs = wide_ff;
	assign xfer_count = xfer_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_flush_op;
		iss_acc && dec.uf_flush && !dec.unimpl_op;
	endsequence

	sequence s_flush_done;
		res_wr && res_flush && cause[`FUX_C_U] && cause[`FUX_C_I];
	endsequence

	a_unimpl_traps: assert property (
		iss_acc && (op_reserved || fmt_invalid) |=>
		trap && !res_wr && cause[`FUX_C_E])
		else $error("unimplemented op did not trap");

	a_denorm_traps: assert property (
		iss_acc && (iss_cls == fux_pkg::FUX_CLS_COMPUTE) && (|opnd_denorm)
		|=> trap && !res_wr)
		else $error("denormal operand did not trap");

	a_move_passes: assert property (
		iss_acc && (iss_cls == fux_pkg::FUX_CLS_MOVE) && !op_reserved &&
		!fmt_invalid && (iss_fmt != fux_pkg::FUX_FMT_RSVD) && !res_nonzero
		&& (en_ff == 5'h00) |=> !trap && res_wr)
		else $error("move trapped");

	a_uf_trap: assert property (
		iss_acc && fux_tiny(res_nonzero, res_exp, iss_fmt) && !fs_ff
		|=> trap && !res_wr && cause == 6'h20)
		else $error("trapping underflow mishandled");

	a_uf_flush: assert property (s_flush_op |=> s_flush_done)
		else $error("flushed underflow not delivered");

	a_flush_rz: assert property (
		s_flush_op ##0 (rm_ff == 2'h1) && !res_sign |=>
		res_flush_val == 64'h0)
		else $error("round-to-zero flush value wrong");

	a_ovf_both: assert property (
		iss_acc && res_overflow && !unimpl |=>
		cause[`FUX_C_O] && cause[`FUX_C_I])
		else $error("overflow without inexact cause");

	a_trap_epc: assert property (
		trap |-> trap_epc == $past(iss_pc) && !iss_ready)
		else $error("trap address or stall wrong");

	a_cause_clear: assert property (
		csr_wr && !iss_acc && (reg_wdata[`FUX_CAUSE_LO +: 6] == 6'h00) |=>
		cause == 6'h00 ##1 iss_ready || !$stable(en_ff) || !$stable(cause))
		else $error("zero write did not clear cause");

	a_xfer_count: assert property (
		xfer_count == (wide_regs ? 6'h20 : 6'h10))
		else $error("save count disagrees with width bit");
endmodule : fux_exc_unit
`default_nettype wire

//--- fux_pipe_model.sv
// Integer pipeline model that offers instructions to the FP exception unit
`timescale 1ns/1ps
`default_nettype none
module fux_pipe_model (
	input wire logic clk_sys,
	input wire logic iss_ready,
	output var logic iss_valid,
	output var fux_pkg::fux_cls_t iss_cls,
	output var fux_pkg::fux_fmt_t iss_fmt,
	output var logic [63:0] iss_pc,
	output var logic op_reserved,
	output var logic fmt_invalid,
	output var logic [1:0] opnd_denorm,
	output var logic [1:0] opnd_qnan,
	output var logic res_nonzero,
	output var logic signed [12:0] res_exp,
	output var logic res_sign,
	output var logic res_inexact,
	output var logic res_overflow,
	output var logic res_divzero,
	output var logic res_invalid
);
	logic [63:0] last_pc;

	initial begin
		iss_valid = 1'b0;
		iss_cls = fux_pkg::FUX_CLS_MOVE;
		iss_fmt = fux_pkg::FUX_FMT_S;
		iss_pc = 64'h0;
		last_pc = 64'h1000;
		{op_reserved, fmt_invalid, opnd_denorm, opnd_qnan} = 6'h00;
		{res_nonzero, res_sign, res_exp} = 15'h0000;
		{res_inexact, res_overflow, res_divzero, res_invalid} = 4'h0;
	end

	// ----------------------------------------
	// Offer one instruction, hold it until taken or 64 cycles pass
	// ----------------------------------------
	task automatic issue(input fux_pkg::fux_cls_t c,
		input fux_pkg::fux_fmt_t f, input logic [7:0] flg,
		input logic signed [12:0] ex, input logic [3:0] cnd);
		int n;
		@(posedge clk_sys);
		last_pc = last_pc + 64'h4;
		iss_valid <= 1'b1;
		iss_cls <= c;
		iss_fmt <= f;
		iss_pc <= last_pc;
		{op_reserved, fmt_invalid, opnd_denorm, opnd_qnan, res_nonzero,
			res_sign} <= flg;
		res_exp <= ex;
		{res_inexact, res_overflow, res_divzero, res_invalid} <= cnd;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (iss_ready !== 1'b1 && n < 64);
		// Released fields except class and format turn over so stale values are never trusted
		iss_valid <= 1'b0;
		iss_pc <= ~last_pc;
		{op_reserved, fmt_invalid, opnd_denorm, opnd_qnan, res_nonzero,
			res_sign} <= ~flg;
		res_exp <= ~ex;
		{res_inexact, res_overflow, res_divzero, res_invalid} <= ~cnd;
	endtask : issue
endmodule : fux_pipe_model
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench of the FP exception unit
`timescale 1ns/1ps
`default_nettype none
`include "fux_consts.svh"
module tb_top;
	logic clk_sys, rst, reg_wr, reg_rd, iss_valid, iss_ready, res_wr;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic op_reserved, fmt_invalid, res_nonzero, res_sign, res_inexact;
	logic res_overflow, res_divzero, res_invalid, res_flush, trap, wide_regs;
	logic [1:0] opnd_denorm, opnd_qnan;
	logic signed [12:0] res_exp;
	logic [63:0] iss_pc, res_flush_val, trap_epc, fv;
	logic [5:0] cause, xfer_count;
	fux_pkg::fux_cls_t iss_cls;
	fux_pkg::fux_fmt_t iss_fmt;
	int fail_count = 0;
	int compares = 0;

	fux_exc_unit #(.ADDR_W(4), .PC_W(64)) u_fux_exc_unit (.clk_sys(clk_sys),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.iss_valid(iss_valid), .iss_cls(iss_cls), .iss_fmt(iss_fmt),
		.iss_pc(iss_pc), .op_reserved(op_reserved), .fmt_invalid(fmt_invalid),
		.opnd_denorm(opnd_denorm), .opnd_qnan(opnd_qnan),
		.res_nonzero(res_nonzero), .res_exp(res_exp), .res_sign(res_sign),
		.res_inexact(res_inexact), .res_overflow(res_overflow),
		.res_divzero(res_divzero), .res_invalid(res_invalid),
		.iss_ready(iss_ready), .res_wr(res_wr), .res_flush(res_flush),
		.res_flush_val(res_flush_val), .trap(trap), .trap_epc(trap_epc),
		.cause(cause), .wide_regs(wide_regs), .xfer_count(xfer_count));

	fux_pipe_model u_fux_pipe_model (.clk_sys(clk_sys),
		.iss_ready(iss_ready), .iss_valid(iss_valid), .iss_cls(iss_cls),
		.iss_fmt(iss_fmt), .iss_pc(iss_pc), .op_reserved(op_reserved),
		.fmt_invalid(fmt_invalid), .opnd_denorm(opnd_denorm),
		.opnd_qnan(opnd_qnan), .res_nonzero(res_nonzero), .res_exp(res_exp),
		.res_sign(res_sign), .res_inexact(res_inexact),
		.res_overflow(res_overflow), .res_divzero(res_divzero),
		.res_invalid(res_invalid));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Checking, bus access and closing
	// ----------------------------------------
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : reg_read

	task automatic end_of_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// Issue one instruction and check the answer in the following cycle
	task automatic op(input fux_pkg::fux_cls_t c, input fux_pkg::fux_fmt_t f,
		input logic [7:0] flg, input logic signed [12:0] ex,
		input logic [3:0] cnd, input logic tr, input logic [5:0] cs,
		input logic fl, input logic [63:0] fv_e);
		u_fux_pipe_model.issue(c, f, flg, ex, cnd);
		#1;
		chk("trap", {63'h0, tr}, {63'h0, trap});
		chk("res_wr", {63'h0, !tr}, {63'h0, res_wr});
		chk("cause", {58'h0, cs}, {58'h0, cause});
		chk("res_flush", {63'h0, fl}, {63'h0, res_flush});
		if (fl)
			chk("res_flush_val", fv_e, res_flush_val);
		if (tr) begin
			chk("trap_epc", u_fux_pipe_model.last_pc, trap_epc);
			@(posedge clk_sys);
			#1 chk("iss_ready", 64'h0, {63'h0, iss_ready});
			reg_read(`FUX_OFF_EPC_LO, rv);
			chk("epc_lo", {32'h0, u_fux_pipe_model.last_pc[31:0]},
				{32'h0, rv});
			reg_read(`FUX_OFF_EPC_HI, rv);
			chk("epc_hi", {32'h0, u_fux_pipe_model.last_pc[63:32]},
				{32'h0, rv});
			reg_write(`FUX_OFF_CSR, 32'h0000_0000);
		end
	endtask : op

	function automatic logic [63:0] flush_exp(input int m, input logic s,
		input logic d);
		logic [63:0] mn, sg;
		mn = d ? `FUX_MIN_D : `FUX_MIN_S;
		sg = 64'h1 << (d ? `FUX_SIGN_D : `FUX_SIGN_S);
		case (m)
			0, 1: return s ? sg : 64'h0;
			2: return s ? sg : mn;
			default: return s ? (sg | mn) : 64'h0;
		endcase
	endfunction : flush_exp

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 38'h0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		#1 chk("xfer_count", 64'h10, {58'h0, xfer_count});
		reg_read(`FUX_OFF_CSR, rv);
		chk("csr", 64'h0, {32'h0, rv});
		reg_write(`FUX_OFF_XFER, 32'h0000_0000);
		reg_read(`FUX_OFF_XFER, rv);
		chk("xfer", 64'h10, {32'h0, rv});
		reg_read(4'hF, rv);
		chk("unmapped", 64'h0, {32'h0, rv});
		reg_write(`FUX_OFF_CFG, 32'h0000_0001);
		reg_read(`FUX_OFF_XFER, rv);
		chk("xfer wide", 64'h20, {32'h0, rv});
		chk("wide_regs", 64'h1, {63'h0, wide_regs});
		reg_write(`FUX_OFF_CFG, 32'h0000_0000);
		for (int d = 0; d < 2; d++)
			for (int m = 0; m < 4; m++)
				for (int s = 0; s < 2; s++) begin
					reg_write(`FUX_OFF_CSR, 32'h0100_0000 | m);
					fv = flush_exp(m, s[0], d[0]);
					op(fux_pkg::FUX_CLS_COMPUTE,
						d ? fux_pkg::FUX_FMT_D : fux_pkg::FUX_FMT_S,
						{7'h01, s[0]}, (d ? `FUX_EMIN_D : `FUX_EMIN_S) - 13'sd1,
						4'h0, 1'b0, 6'h03, 1'b1, fv);
				end
		op(fux_pkg::FUX_CLS_COMPUTE, fux_pkg::FUX_FMT_S, 8'h02, `FUX_EMIN_S,
			4'h8, 1'b0, 6'h01, 1'b0, 64'h0);
		for (int i = 0; i < 3; i++) begin
			reg_write(`FUX_OFF_CSR, (i == 0) ? 32'h0000_0000 :
				(i == 1) ? 32'h0100_0100 : 32'h0100_0080);
			op(fux_pkg::FUX_CLS_COMPUTE, fux_pkg::FUX_FMT_D, 8'h02,
				`FUX_EMIN_D - 13'sd1, 4'h8, 1'b1, 6'h20, 1'b0, 64'h0);
		end
		op(fux_pkg::FUX_CLS_COMPUTE, fux_pkg::FUX_FMT_S, 8'h80, 13'sh0, 4'h0,
			1'b1, 6'h20, 1'b0, 64'h0);
		op(fux_pkg::FUX_CLS_COMPUTE, fux_pkg::FUX_FMT_RSVD, 8'h00, 13'sh0,
			4'h0, 1'b1, 6'h20, 1'b0, 64'h0);
		op(fux_pkg::FUX_CLS_CONVERT, fux_pkg::FUX_FMT_S, 8'h40, 13'sh0, 4'h0,
			1'b1, 6'h20, 1'b0, 64'h0);
		op(fux_pkg::FUX_CLS_COMPUTE, fux_pkg::FUX_FMT_D, 8'h20, 13'sh0, 4'h0,
			1'b1, 6'h20, 1'b0, 64'h0);
		op(fux_pkg::FUX_CLS_CONVERT, fux_pkg::FUX_FMT_D, 8'h04, 13'sh0, 4'h0,
			1'b1, 6'h20, 1'b0, 64'h0);
		op(fux_pkg::FUX_CLS_COMPARE, fux_pkg::FUX_FMT_S, 8'h1C, 13'sh0, 4'h0,
			1'b0, 6'h00, 1'b0, 64'h0);
		op(fux_pkg::FUX_CLS_MOVE, fux_pkg::FUX_FMT_D, 8'h3C, 13'sh0, 4'h0,
			1'b0, 6'h00, 1'b0, 64'h0);
		op(fux_pkg::FUX_CLS_COMPUTE, fux_pkg::FUX_FMT_S, 8'h02, 13'sh0, 4'hC,
			1'b0, 6'h05, 1'b0, 64'h0);
		// Save: flags I,O and causes I,O are held
		reg_read(`FUX_OFF_CSR, rv);
		chk("csr saved", 64'h5014, {32'h0, rv});
		reg_write(`FUX_OFF_CSR, 32'h0002_0000);
		@(posedge clk_sys);
		#1 chk("iss_ready pend", 64'h0, {63'h0, iss_ready});
		reg_read(`FUX_OFF_CSR, rv);
		chk("csr restored", 64'h2_0000, {32'h0, rv});
		reg_write(`FUX_OFF_CSR, 32'h0000_0000);
		@(posedge clk_sys);
		#1 chk("iss_ready clear", 64'h1, {63'h0, iss_ready});
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
